// *** core/crwrt_top.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - PM bit zero forces capability pointer zero
// - PM bit mirrored to config word bit 20
// - PM mode wakes on magic, unicast, multicast
// - Setting WAKE_LAN_ENABLE enters wake mode and sleeps
// - Sleep ends on wake, WAKE_LAN_ENABLE clear, reset
// - WAKE_LAN_ENABLE mode wakes on magic frame only
// - Pattern pointer reset bit rewinds pointer
// - Pause bit loaded from autonegotiation, then writable
// - Pause bit enables or disables PAUSE
// - Threshold enable off forces 64-byte threshold
// - Drain code: 32, 64, store-forward, reserved
// - Underrun recovery bit recovers without software
// - FIFO size code 11 is 1K, 10 is 2K
module crwrt_top
  import crwrt_pkg::*;
#(
  parameter logic [7:0] CAP_PTR_VALUE = 8'h50  // Capability list start
)(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          soft_reset,
  // Avalon-MM slave
  input  wire logic [crwrt_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [crwrt_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [crwrt_pkg::DATA_W-1:0]  avs_readdata,
  output logic                               avs_waitrequest,
  // EEPROM recall
  input  wire logic                          eeprom_load,
  input  wire logic                          eeprom_pm_enable,
  input  wire logic                          eeprom_wol_enable,
  input  wire logic [1:0]                    eeprom_rx_fifo_size,
  // Autonegotiation result
  input  wire logic                          an_done,
  input  wire logic                          an_pause_able,
  // Frame classifier and transmitter events
  input  wire logic                          magic_frame_rx,
  input  wire logic                          unicast_wake_rx,
  input  wire logic                          multicast_wake_rx,
  input  wire logic                          tx_underrun,
  // Controls to the datapath
  output logic      [7:0]                    cap_ptr,
  output logic                               new_cap_ind,
  output logic                               sleep_state,
  output logic                               wake_event,
  output logic                               pattern_ptr_rewind,
  output logic                               pause_enable,
  output logic      [11:0]                   rx_threshold_bytes,
  output logic                               rx_store_forward,
  output logic      [11:0]                   rx_fifo_bytes,
  output logic                               tx_recover,
  output logic                               tx_stalled,
  output logic                               irq
);
  import crwrt_pkg::*;

  // Command register fields
  logic                power_mgmt_enable_r;       // Read-only to software
  logic                wake_lan_enable_r;         // Wake on LAN enable
  logic                pattern_pointer_reset_r;   // Stored rewind bit
  logic                pause_r;                   // Pause enable
  logic                rx_threshold_enable_r;     // Threshold enable
  logic [1:0]          rx_drain_threshold_r;      // Drain code
  logic                software_irq_r;            // Software interrupt
  logic                auto_underrun_recovery_r;  // Underrun recovery
  logic [1:0]          rx_fifo_size_sel_r;        // Rx FIFO size code
  logic                an_seen_r;                 // Autonegotiation done once
  crwrt_pwr_type       pwr_r;                     // Sleep state
  crwrt_pwr_type       pwr_nxt;
  logic [IRQ_W-1:0]    irq_stat_r;                // Sticky events
  logic [IRQ_W-1:0]    irq_mask_r;                // Event mask
  logic                stall_r;                   // Tx halted on underrun
  logic                wake_r;                    // Wake pulse
  logic                rewind_r;                  // Rewind pulse
  logic                recover_r;                 // Recovery pulse
  logic                ack_r;                     // Bus answer phase
  logic [DATA_W-1:0]   rdata_r;                   // Registered read data

  // Bus decode; a write lands only in the answer cycle, so a
  // request held through its wait cycle is applied once
  wire                 req      = avs_read | avs_write;
  wire                 wr_take  = avs_write & ack_r;
  wire                 hit_cmd  = (avs_address == OFS_CMD);
  wire                 hit_cfg  = (avs_address == OFS_CFG_ID);
  wire                 hit_stat = (avs_address == OFS_IRQ_STAT);
  wire                 hit_mask = (avs_address == OFS_IRQ_MASK);
  wire                 hit_st   = (avs_address == OFS_STATE);
  wire                 wr_cmd   = wr_take & hit_cmd;
  wire                 wr_stat  = wr_take & hit_stat;
  wire                 wr_mask  = wr_take & hit_mask;

  // Byte enables widened to a bit mask, one lane per loop pass
  logic [DATA_W-1:0]   be_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // Merged command word as it will stand after a write
  logic [DATA_W-1:0]   cmd_now;
  wire  [DATA_W-1:0]   cmd_wmask = be_mask & CMD_WR_MASK;
  wire  [DATA_W-1:0]   cmd_new   = (cmd_now & ~cmd_wmask) | (avs_writedata & cmd_wmask);
  wire  [DATA_W-1:0]   wdat_be   = avs_writedata & be_mask;

  // Current command word image
  always_comb begin
    cmd_now                       = '0;
    cmd_now[B_RFS_HI:B_RFS_LO]    = rx_fifo_size_sel_r;
    cmd_now[B_PM]                 = power_mgmt_enable_r;
    cmd_now[B_WOL]                = wake_lan_enable_r;
    cmd_now[B_RWP]                = pattern_pointer_reset_r;
    cmd_now[B_PAUSE]              = pause_r;
    cmd_now[B_RTE]                = rx_threshold_enable_r;
    cmd_now[B_DRT_HI:B_DRT_LO]    = rx_drain_threshold_r;
    cmd_now[B_SOFTWARE_IRQ]               = software_irq_r;
    cmd_now[B_AUTO_UNDERRUN_RECOVERY]               = auto_underrun_recovery_r;
  end

  // Config word 1 image with the new-capabilities bit
  logic [DATA_W-1:0]   cfg_word;
  always_comb begin
    cfg_word             = '0;
    cfg_word[B_NEW_CAP]  = power_mgmt_enable_r;
  end

  // Live state word
  // Software can poll sleep and stall without touching status
  wire  [DATA_W-1:0]   state_word = {20'h00000, stall_r, (pwr_r == PS_ASLEEP), 2'h0, cap_ptr};

  // Read mux, unmapped addresses read zero
  wire  [DATA_W-1:0]   rd_mux =
      hit_cmd  ? cmd_now :
      hit_cfg  ? cfg_word :
      hit_stat ? {29'h0, irq_stat_r} :
      hit_mask ? {29'h0, irq_mask_r} :
      hit_st   ? state_word : 32'h00000000;

  // Wake frame qualification by mode
  // Asleep only magic frames count; awake, PM mode with WAKE_LAN_ENABLE off takes all three
  wire                 wol_wake = wake_lan_enable_r & magic_frame_rx;
  wire                 pm_wake  = power_mgmt_enable_r & ~wake_lan_enable_r &
                                  (magic_frame_rx | unicast_wake_rx | multicast_wake_rx);
  wire                 wake_hit = (pwr_r == PS_ASLEEP) ? wol_wake : pm_wake;

  // WAKE_LAN_ENABLE level after this cycle's load or write
  wire                 wol_set  = (wr_cmd & cmd_new[B_WOL] & cmd_wmask[B_WOL]) |
                                  (eeprom_load & eeprom_wol_enable);
  // A recall with WAKE_LAN_ENABLE at zero ends sleep just as a write of zero does
  wire                 wol_clr  = (wr_cmd & cmd_wmask[B_WOL] & ~cmd_new[B_WOL]) |
                                  (eeprom_load & ~eeprom_wol_enable);

  // Sleep state transitions
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PS_AWAKE: begin
        // Enter sleep whenever WAKE_LAN_ENABLE is set
        if (wol_set) begin
          pwr_nxt = PS_ASLEEP;
        end
      end
      PS_ASLEEP: begin
        // Leave on wake frame or WAKE_LAN_ENABLE cleared
        if (wol_wake || wol_clr) begin
          pwr_nxt = PS_AWAKE;
        end
      end
      default: begin
        pwr_nxt = PS_AWAKE;
      end
    endcase
  end

  // Event sources for the sticky status
  logic [IRQ_W-1:0]    ev;
  always_comb begin
    ev              = '0;
    ev[EV_WAKE]     = wake_hit;
    ev[EV_UNDERRUN] = tx_underrun;
    ev[EV_SLEEP]    = (pwr_r == PS_AWAKE) && (pwr_nxt == PS_ASLEEP);
  end

  // Bus handshake: one wait cycle, then answer
  // The wait cycle lets the read mux settle into a register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= req & ~ack_r;
      // Read data captured on the wait cycle
      if (avs_read && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Power management and WAKE_LAN_ENABLE bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mgmt_enable_r <= 1'b0;
      wake_lan_enable_r   <= 1'b0;
      rx_fifo_size_sel_r  <= RFS_RESET;
      pwr_r               <= PS_AWAKE;
    end else if (soft_reset) begin
      // Software reset wakes the block and drops WAKE_LAN_ENABLE
      wake_lan_enable_r   <= 1'b0;
      pwr_r               <= PS_AWAKE;
    end else if (eeprom_load) begin
      // Recall from EEPROM
      power_mgmt_enable_r <= eeprom_pm_enable;
      wake_lan_enable_r   <= eeprom_wol_enable;
      rx_fifo_size_sel_r  <= eeprom_rx_fifo_size;
      pwr_r               <= pwr_nxt;
    end else begin
      // PM bit has no write path
      if (wr_cmd) begin
        wake_lan_enable_r   <= cmd_new[B_WOL];
        rx_fifo_size_sel_r  <= cmd_new[B_RFS_HI:B_RFS_LO];
      end
      pwr_r <= pwr_nxt;
    end
  end

  // Pause bit: autonegotiation first, software afterwards
  // Early writes are dropped so software cannot race the negotiation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_r   <= 1'b0;
      an_seen_r <= 1'b0;
    end else if (soft_reset) begin
      pause_r   <= 1'b0;
      an_seen_r <= 1'b0;
    end else if (an_done) begin
      pause_r   <= an_pause_able;
      an_seen_r <= 1'b1;
    end else if (wr_cmd && an_seen_r) begin
      pause_r   <= cmd_new[B_PAUSE];
    end
  end

  // Remaining software controls
  // Soft reset returns these to their power-up values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_pointer_reset_r  <= 1'b0;
      rx_threshold_enable_r    <= 1'b0;
      rx_drain_threshold_r     <= DRT_RESET;
      software_irq_r           <= 1'b0;
      auto_underrun_recovery_r <= 1'b0;
    end else if (soft_reset) begin
      pattern_pointer_reset_r  <= 1'b0;
      rx_threshold_enable_r    <= 1'b0;
      rx_drain_threshold_r     <= DRT_RESET;
      software_irq_r           <= 1'b0;
      auto_underrun_recovery_r <= 1'b0;
    end else if (wr_cmd) begin
      pattern_pointer_reset_r  <= cmd_new[B_RWP];
      rx_threshold_enable_r    <= cmd_new[B_RTE];
      rx_drain_threshold_r     <= cmd_new[B_DRT_HI:B_DRT_LO];
      software_irq_r           <= cmd_new[B_SOFTWARE_IRQ];
      auto_underrun_recovery_r <= cmd_new[B_AUTO_UNDERRUN_RECOVERY];
    end
  end

  // Sticky status and mask; a new event beats a clear
  // Software clears with ones; zero bits leave status alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~({IRQ_W{wr_stat}} & wdat_be[IRQ_W-1:0])) | ev;
      if (wr_mask) begin
        irq_mask_r <= (irq_mask_r & ~be_mask[IRQ_W-1:0]) | wdat_be[IRQ_W-1:0];
      end
    end
  end

  // Pulses and the underrun stall
  // Rewind follows the written bit, so every write of one rewinds
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_r    <= 1'b0;
      rewind_r  <= 1'b0;
      recover_r <= 1'b0;
      stall_r   <= 1'b0;
    end else begin
      wake_r    <= wake_hit;
      rewind_r  <= wr_cmd & cmd_wmask[B_RWP] & avs_writedata[B_RWP];
      recover_r <= tx_underrun & auto_underrun_recovery_r;
      // Without recovery the transmitter waits for software
      if (tx_underrun && !auto_underrun_recovery_r) begin
        stall_r <= 1'b1;
      end else if (soft_reset || (wr_stat && wdat_be[EV_UNDERRUN])) begin
        stall_r <= 1'b0;
      end
    end
  end

  // Effective receive threshold
  // Store-and-forward keeps the 64-byte figure; the flag tells the
  // datapath to wait for the whole frame
  logic [11:0]         thr_bytes;
  always_comb begin
    thr_bytes = BYTES_64;
    if (rx_threshold_enable_r) begin
      case (rx_drain_threshold_r)
        DRT_32B: thr_bytes = BYTES_32;
        DRT_64B: thr_bytes = BYTES_64;
        default: thr_bytes = BYTES_64;
      endcase
    end
  end

  // Receive FIFO size decode, reserved codes fall back to 2K
  // so a blank EEPROM never shrinks the buffer
  wire  [11:0]         fifo_bytes = (rx_fifo_size_sel_r == RFS_1K) ? BYTES_1K : BYTES_2K;

  // Outputs
  assign avs_waitrequest    = req & ~ack_r;
  assign avs_readdata       = rdata_r;
  assign cap_ptr            = power_mgmt_enable_r ? CAP_PTR_VALUE : 8'h00;
  assign new_cap_ind        = power_mgmt_enable_r;
  assign sleep_state        = (pwr_r == PS_ASLEEP);
  assign wake_event         = wake_r;
  assign pattern_ptr_rewind = rewind_r;
  assign pause_enable       = pause_r;
  assign rx_threshold_bytes = thr_bytes;
  assign rx_store_forward   = rx_threshold_enable_r && (rx_drain_threshold_r == DRT_SAF);
  assign rx_fifo_bytes      = fifo_bytes;
  assign tx_recover         = recover_r;
  assign tx_stalled         = stall_r;
  assign irq                = (|(irq_stat_r & irq_mask_r)) | software_irq_r;

endmodule // crwrt_top

// *** inc/crwrt_pkg.sv ***
// Shared constants for the command register block
package crwrt_pkg;

  // Bus geometry
  localparam int          ADDR_W          = 8;      // Byte address width
  localparam int          DATA_W          = 32;     // Data word width

  // Register byte offsets
  localparam logic [7:0]  OFS_CFG_ID      = 8'h04;  // Config word 1 image
  localparam logic [7:0]  OFS_CMD         = 8'h88;  // Command register
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'hA0;  // Sticky event status
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'hA4;  // Event mask
  localparam logic [7:0]  OFS_STATE       = 8'hA8;  // Live block state

  // Command register field positions
  localparam int          B_RFS_HI        = 22;     // Rx FIFO size field top
  localparam int          B_RFS_LO        = 21;     // Rx FIFO size field bottom
  localparam int          B_PM            = 19;     // Power management enable
  localparam int          B_WOL           = 18;     // Wake on LAN enable
  localparam int          B_RWP           = 6;      // Pattern pointer reset
  localparam int          B_PAUSE         = 5;      // Flow-control pause enable
  localparam int          B_RTE           = 4;      // Rx threshold enable
  localparam int          B_DRT_HI        = 3;      // Drain threshold top
  localparam int          B_DRT_LO        = 2;      // Drain threshold bottom
  localparam int          B_SOFTWARE_IRQ          = 1;      // Software interrupt
  localparam int          B_AUTO_UNDERRUN_RECOVERY          = 0;      // Auto underrun recovery

  // Config word 1 new-capabilities bit
  localparam int          B_NEW_CAP       = 20;

  // Software-writable bits of the command register
  localparam logic [31:0] CMD_WR_MASK     = 32'h0064007F;

  // Reset values
  localparam logic [1:0]  DRT_RESET       = 2'h1;   // 64-byte drain
  localparam logic [1:0]  RFS_RESET       = 2'h2;   // 2K bytes

  // Drain threshold codes
  localparam logic [1:0]  DRT_32B         = 2'h0;
  localparam logic [1:0]  DRT_64B         = 2'h1;
  localparam logic [1:0]  DRT_SAF         = 2'h2;

  // Rx FIFO size codes
  localparam logic [1:0]  RFS_1K          = 2'h3;
  localparam logic [1:0]  RFS_2K          = 2'h2;

  // Threshold and size values in bytes
  localparam logic [11:0] BYTES_32        = 12'h020;
  localparam logic [11:0] BYTES_64        = 12'h040;
  localparam logic [11:0] BYTES_1K        = 12'h400;
  localparam logic [11:0] BYTES_2K        = 12'h800;

  // Interrupt status bit positions
  localparam int          IRQ_W           = 3;
  localparam int          EV_WAKE         = 0;      // Wake-up frame seen
  localparam int          EV_UNDERRUN     = 1;      // Tx FIFO underrun
  localparam int          EV_SLEEP        = 2;      // Sleep entered

  // Power state of the wake logic
  typedef enum logic {
    PS_AWAKE,
    PS_ASLEEP
  } crwrt_pwr_type;

endpackage

// *** testbench/crwrt_props.sv ***
`timescale 1ns/1ns
// Port-level checks of the command register block
module crwrt_props
  import crwrt_pkg::*;
#(
  parameter logic [7:0] CAP_PTR_VALUE = 8'h50  // Same start as the design
)(
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        soft_reset,
  input wire logic [crwrt_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [crwrt_pkg::DATA_W-1:0] avs_writedata,
  input wire logic                        avs_waitrequest,
  input wire logic                        eeprom_load,
  input wire logic                        eeprom_pm_enable,
  input wire logic [1:0]                  eeprom_rx_fifo_size,
  input wire logic                        magic_frame_rx,
  input wire logic                        unicast_wake_rx,
  input wire logic                        multicast_wake_rx,
  input wire logic [7:0]                  cap_ptr,
  input wire logic                        new_cap_ind,
  input wire logic                        sleep_state,
  input wire logic                        wake_event,
  input wire logic                        pattern_ptr_rewind,
  input wire logic [11:0]                 rx_threshold_bytes,
  input wire logic                        rx_store_forward,
  input wire logic [11:0]                 rx_fifo_bytes
);
  // One domain: shared clock and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  cap_ptr_gate_a: assert property (cap_ptr == (new_cap_ind ? CAP_PTR_VALUE : 8'h00))
    else $error("cap_ptr does not follow the power management bit");
  pm_recall_a: assert property (eeprom_load |=> new_cap_ind == $past(eeprom_pm_enable))
    else $error("new capability flag not loaded from recall");
  fifo_size_a: assert property (eeprom_load |=> rx_fifo_bytes ==
    ($past(eeprom_rx_fifo_size) == 2'h3 ? BYTES_1K : BYTES_2K))
    else $error("fifo size does not match recalled code");
  magic_wake_a: assert property (sleep_state && magic_frame_rx && !soft_reset
    && !avs_write && !eeprom_load |=> wake_event && !sleep_state)
    else $error("magic frame did not wake the sleeping block");
  other_ignored_a: assert property (sleep_state && !magic_frame_rx
    && (unicast_wake_rx || multicast_wake_rx) |=> !wake_event)
    else $error("non-magic frame woke the sleeping block");
  sleep_hold_a: assert property (sleep_state && !magic_frame_rx && !soft_reset
    && !avs_write && !eeprom_load |=> sleep_state)
    else $error("sleep left without a cause");
  thresh_set_a: assert property (rx_threshold_bytes == BYTES_32 ? !rx_store_forward
    : rx_threshold_bytes == BYTES_64)
    else $error("receive threshold outside allowed values");
  rewind_cause_a: assert property (pattern_ptr_rewind |-> $past(avs_write
    && !avs_waitrequest && avs_address == OFS_CMD && avs_writedata[B_RWP]))
    else $error("pointer rewind without a write of the reset bit");
  wake_source_a: assert property (wake_event |->
    $past(magic_frame_rx || unicast_wake_rx || multicast_wake_rx))
    else $error("wake event without a frame");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one cycle");
endmodule // crwrt_props

bind crwrt_top crwrt_props #(.CAP_PTR_VALUE(CAP_PTR_VALUE)) i_props (
  .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .eeprom_load(eeprom_load),
  .eeprom_pm_enable(eeprom_pm_enable), .eeprom_rx_fifo_size(eeprom_rx_fifo_size),
  .magic_frame_rx(magic_frame_rx), .unicast_wake_rx(unicast_wake_rx),
  .multicast_wake_rx(multicast_wake_rx), .cap_ptr(cap_ptr), .new_cap_ind(new_cap_ind),
  .sleep_state(sleep_state), .wake_event(wake_event),
  .pattern_ptr_rewind(pattern_ptr_rewind), .rx_threshold_bytes(rx_threshold_bytes),
  .rx_store_forward(rx_store_forward), .rx_fifo_bytes(rx_fifo_bytes));

// *** testbench/command_reg_wake_rx_threshold_tb_top.sv ***
`timescale 1ns/1ns
// Self-checking bench for the command register block
module command_reg_wake_rx_threshold_tb_top;
  import crwrt_pkg::*;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, cap_ptr;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0]  ev;  // Event pulses, one bit per input
  logic        new_cap_ind, sleep_state, wake_event, pattern_ptr_rewind, pause_enable;
  logic        rx_store_forward, tx_recover, tx_stalled, irq;
  logic [11:0] rx_threshold_bytes, rx_fifo_bytes;
  logic        eeprom_wol_enable, an_pause_able;  // Recall and negotiation levels
  int          error_cnt, cmp_count;

  crwrt_top #(.CAP_PTR_VALUE(8'h50)) i_dut (
    .clk(clk), .rst_b(rst_b), .soft_reset(ev[6]), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .eeprom_load(ev[5]), .eeprom_pm_enable(1'b1), .eeprom_wol_enable(eeprom_wol_enable),
    .eeprom_rx_fifo_size(2'h3), .an_done(ev[4]), .an_pause_able(an_pause_able),
    .magic_frame_rx(ev[0]), .unicast_wake_rx(ev[1]), .multicast_wake_rx(ev[2]),
    .tx_underrun(ev[3]), .cap_ptr(cap_ptr), .new_cap_ind(new_cap_ind),
    .sleep_state(sleep_state), .wake_event(wake_event),
    .pattern_ptr_rewind(pattern_ptr_rewind), .pause_enable(pause_enable),
    .rx_threshold_bytes(rx_threshold_bytes), .rx_store_forward(rx_store_forward),
    .rx_fifo_bytes(rx_fifo_bytes), .tx_recover(tx_recover), .tx_stalled(tx_stalled),
    .irq(irq));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Closing report and end of run
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  // Bus write, held until waitrequest is seen low
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Bus read, data taken at the accepting edge
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // One-cycle event pulse, then settle to mid-cycle
  task fire(input int k);
    @(posedge clk);
    ev <= 7'h01 << k;
    @(posedge clk);
    ev <= 7'h00;
    @(negedge clk);
  endtask

  // Values right after reset, unmapped read
  task t_reset;
    logic [31:0] d;
    rd(OFS_CMD, d);
    chk("cmd reset", 32'h00400004, d);
    rd(8'h10, d);
    chk("unmapped", 32'h0, d);
    chk("threshold", 32'h40, 32'(rx_threshold_bytes));
    chk("fifo", 32'h800, 32'(rx_fifo_bytes));
    chk("cap_ptr", 32'h0, 32'(cap_ptr));
  endtask

  // Recall enables power management; all frames wake
  task t_pm;
    logic [31:0] d;
    fire(5);
    chk("cap_ptr", 32'h50, 32'(cap_ptr));
    chk("new cap", 32'h1, 32'(new_cap_ind));
    chk("fifo 1k", 32'h400, 32'(rx_fifo_bytes));
    rd(OFS_CFG_ID, d);
    chk("cfg bit", 32'h1, 32'(d[B_NEW_CAP]));
    wr(OFS_CMD, 32'h00600004);
    rd(OFS_CMD, d);
    chk("pm kept", 32'h00680004, d);
    for (int i = 0; i < 3; i++) begin
      fire(i);
      chk("pm wake", 32'h1, 32'(wake_event));
    end
  endtask

  // Pause bit locked until negotiation, then writable
  task t_pause;
    wr(OFS_CMD, 32'h00600024);
    @(negedge clk);
    chk("pause early", 32'h0, 32'(pause_enable));
    fire(4);
    chk("pause an", 32'h1, 32'(pause_enable));
    wr(OFS_CMD, 32'h00600004);
    @(negedge clk);
    chk("pause off", 32'h0, 32'(pause_enable));
    wr(OFS_CMD, 32'h00600024);
    an_pause_able <= 1'b0;
    @(negedge clk);
    chk("pause on", 32'h1, 32'(pause_enable));
    fire(4);
    chk("pause an 0", 32'h0, 32'(pause_enable));
  endtask

  // Every drain code with threshold on, then threshold off
  task t_thresh;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CMD, 32'h00600010 | (i << 2));
      @(negedge clk);
      chk("drain", (i == 0) ? 32'h20 : 32'h40, 32'(rx_threshold_bytes));
      chk("saf", 32'(i == 2), 32'(rx_store_forward));
    end
    wr(OFS_CMD, 32'h00600000);
    @(negedge clk);
    chk("rte off", 32'h40, 32'(rx_threshold_bytes));
  endtask

  // Pointer rewind pulses once
  task t_rwp;
    wr(OFS_CMD, 32'h00600044);
    @(negedge clk);
    chk("rewind", 32'h1, 32'(pattern_ptr_rewind));
    @(negedge clk);
    chk("rewind end", 32'h0, 32'(pattern_ptr_rewind));
  endtask

  // Underrun status, mask, clear, software request, recovery
  task t_irq;
    logic [31:0] d;
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_CMD, 32'h00600004);
    fire(3);
    chk("stall", 32'h1, 32'(tx_stalled));
    chk("masked", 32'h0, 32'(irq));
    rd(OFS_STATE, d);
    chk("state", 32'h850, d);
    rd(OFS_IRQ_STAT, d);
    chk("status", 32'h2, d);
    wr(OFS_IRQ_MASK, 32'h2);
    @(negedge clk);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h2);
    @(negedge clk);
    chk("irq clr", 32'h0, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_CMD, 32'h00600006);
    @(negedge clk);
    chk("sw irq", 32'h1, 32'(irq));
    wr(OFS_CMD, 32'h00600005);
    @(negedge clk);
    chk("sw irq off", 32'h0, 32'(irq));
    fire(3);
    chk("recover", 32'h1, 32'(tx_recover));
    chk("no stall", 32'h0, 32'(tx_stalled));
  endtask

  // Sleep entry and each way out
  task t_wol;
    logic [31:0] d;
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_CMD, 32'h00640004);
    @(negedge clk);
    chk("sleep", 32'h1, 32'(sleep_state));
    for (int i = 1; i < 3; i++) begin
      fire(i);
      chk("no wake", 32'h0, 32'(wake_event));
      chk("asleep", 32'h1, 32'(sleep_state));
    end
    fire(0);
    chk("magic wake", 32'h1, 32'(wake_event));
    chk("awake", 32'h0, 32'(sleep_state));
    rd(OFS_IRQ_STAT, d);
    chk("wake stat", 32'h5, d);
    wr(OFS_CMD, 32'h00640004);
    wr(OFS_CMD, 32'h00600004);
    @(negedge clk);
    chk("wol clear", 32'h0, 32'(sleep_state));
    wr(OFS_CMD, 32'h00640004);
    fire(6);
    chk("soft reset", 32'h0, 32'(sleep_state));
    wr(OFS_CMD, 32'h00640004);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("hard reset", 32'h0, 32'(sleep_state));
    rd(OFS_CMD, d);
    chk("cmd again", 32'h00400004, d);
    eeprom_wol_enable <= 1'b1;
    fire(5);
    chk("recall wol", 32'h1, 32'(sleep_state));
    @(posedge clk);
    eeprom_wol_enable <= 1'b0;
    fire(5);
    chk("recall clr", 32'h0, 32'(sleep_state));
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    ev = 7'h00;
    eeprom_wol_enable = 1'b0;
    an_pause_able = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_pm;
    t_pause;
    t_thresh;
    t_rwp;
    t_irq;
    t_wol;
    give_verdict;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
endmodule // command_reg_wake_rx_threshold_tb_top
